// ### shared/xfer_decode_pkg.sv
// package: opcodes, operation classes and clock-count figures
// assumes: used by the decode and timing block and its sub-module
`default_nettype none
package xfer_decode_pkg;
    // opcode bytes
    localparam logic [7:0] OPC_REP_NE = 8'h00_F2;
    localparam logic [7:0] OPC_REP_E = 8'h00_F3;
    localparam logic [7:0] OPC_ESCAPE = 8'h00_0F;
    localparam logic [6:0] OPC_CMPS = 7'h00_53;
    localparam logic [6:0] OPC_INS = 7'h00_36;
    localparam logic [6:0] OPC_LODS = 7'h00_56;
    localparam logic [6:0] OPC_MOVS = 7'h00_52;
    localparam logic [6:0] OPC_OUTS = 7'h00_37;
    localparam logic [6:0] OPC_SCAS = 7'h00_57;
    localparam logic [6:0] OPC_STOS = 7'h00_55;
    localparam logic [7:0] OPC_SCAN_FWD = 8'h00_BC;
    localparam logic [6:0] OPC_SCAN_REV = 7'h00_5E;
    localparam logic [7:0] OPC_TEST_GRP = 8'h00_BA;
    localparam logic [7:0] OPC_TEST_REG = 8'h00_A3;
    localparam logic [7:0] OPC_TEST_CPL_REG = 8'h00_BB;
    localparam logic [7:0] OPC_TEST_CLR_REG = 8'h00_B3;
    localparam logic [7:0] OPC_TEST_SET_REG = 8'h00_AB;
    localparam logic [7:0] OPC_CALL_NEAR = 8'h00_E8;
    localparam logic [7:0] OPC_CALL_FAR = 8'h00_9A;
    localparam logic [7:0] OPC_GRP_FF = 8'h00_FF;
    localparam logic [7:0] OPC_JUMP_SHORT = 8'h00_EB;
    localparam logic [7:0] OPC_JUMP_NEAR = 8'h00_E9;
    localparam logic [7:0] OPC_JUMP_FAR = 8'h00_EA;
    // modrm extension codes
    localparam logic [2:0] EXT_CALL_NEAR = 3'h0_2;
    localparam logic [2:0] EXT_CALL_FAR = 3'h0_3;
    localparam logic [2:0] EXT_JUMP_NEAR = 3'h0_4;
    localparam logic [2:0] EXT_TEST = 3'h0_4;
    localparam logic [2:0] EXT_TEST_SET = 3'h0_5;
    localparam logic [2:0] EXT_TEST_CLR = 3'h0_6;
    localparam logic [2:0] EXT_TEST_CPL = 3'h0_7;
    localparam logic [1:0] MOD_REG = 2'h0_3;

    typedef enum logic [4:0] {
        OP_NONE = 5'b00000,
        OP_REPEAT_COMPARE_UNTIL_MATCH = 5'b00001,
        OP_REPEAT_PORT_INPUT_STRING = 5'b00010,
        OP_REPEAT_LOAD_STRING = 5'b00011,
        OP_REPEAT_MOVE_STRING = 5'b00100,
        OP_REPEAT_PORT_OUTPUT_STRING = 5'b00101,
        OP_REPEAT_SCAN_WHILE_EQUAL = 5'b00110,
        OP_REPEAT_SCAN_UNTIL_EQUAL = 5'b00111,
        OP_REPEAT_STORE_STRING = 5'b01000,
        OP_BIT_SCAN_FORWARD = 5'b01001,
        OP_BIT_SCAN_REVERSE = 5'b01010,
        OP_BIT_TEST_PLAIN = 5'b01011,
        OP_BIT_TEST_COMPLEMENT = 5'b01100,
        OP_BIT_TEST_CLEAR = 5'b01101,
        OP_BIT_TEST_SET_OP = 5'b01110,
        OP_CALL_NEAR_DIRECT = 5'b01111,
        OP_CALL_NEAR_INDIRECT = 5'b10000,
        OP_CALL_FAR_DIRECT = 5'b10001,
        OP_CALL_FAR_INDIRECT = 5'b10010,
        OP_JUMP_SHORT = 5'b10011,
        OP_JUMP_NEAR_DIRECT = 5'b10100,
        OP_JUMP_NEAR_INDIRECT = 5'b10101,
        OP_JUMP_FAR_DIRECT = 5'b10110
    } op_class_t;

    // clock counts: base + per_step * n (+ m for transfers)
    localparam logic [7:0] CLK_CMPS_BASE = 8'h00_05;
    localparam logic [7:0] CLK_CMPS_STEP = 8'h00_09;
    localparam logic [7:0] CLK_INS_BASE = 8'h00_07;
    localparam logic [7:0] CLK_INS_BASE_ALT = 8'h00_1B;
    localparam logic [7:0] CLK_INS_STEP = 8'h00_06;
    localparam logic [7:0] CLK_LODS_BASE = 8'h00_05;
    localparam logic [7:0] CLK_LODS_STEP = 8'h00_06;
    localparam logic [7:0] CLK_MOVS_BASE = 8'h00_07;
    localparam logic [7:0] CLK_MOVS_STEP = 8'h00_04;
    localparam logic [7:0] CLK_OUTS_BASE = 8'h00_06;
    localparam logic [7:0] CLK_OUTS_BASE_ALT = 8'h00_1A;
    localparam logic [7:0] CLK_OUTS_STEP = 8'h00_05;
    localparam logic [7:0] CLK_SCAS_BASE = 8'h00_05;
    localparam logic [7:0] CLK_SCAS_STEP = 8'h00_08;
    localparam logic [7:0] CLK_STOS_BASE = 8'h00_05;
    localparam logic [7:0] CLK_STOS_STEP = 8'h00_05;
    localparam logic [7:0] CLK_BSCAN_BASE = 8'h00_0A;
    localparam logic [7:0] CLK_BSCAN_STEP = 8'h00_03;
    localparam logic [7:0] CLK_TEST_REG = 8'h00_03;
    localparam logic [7:0] CLK_TEST_IMM_MEM = 8'h00_06;
    localparam logic [7:0] CLK_TEST_REG_MEM = 8'h00_0C;
    localparam logic [7:0] CLK_BTX_REG = 8'h00_06;
    localparam logic [7:0] CLK_BTX_IMM_MEM = 8'h00_08;
    localparam logic [7:0] CLK_BTX_REG_MEM = 8'h00_0D;
    localparam logic [7:0] CLK_CALL_NEAR = 8'h00_09;
    localparam logic [7:0] CLK_CALL_IND_MEM = 8'h00_0C;
    localparam logic [7:0] CLK_CALL_FAR = 8'h00_2A;
    localparam logic [7:0] CLK_CALL_FAR_IND = 8'h00_2E;
    localparam logic [7:0] CLK_JUMP_DIRECT = 8'h00_07;
    localparam logic [7:0] CLK_JUMP_IND_REG = 8'h00_09;
    localparam logic [7:0] CLK_JUMP_IND_MEM = 8'h00_0E;
    localparam logic [7:0] CLK_JUMP_FAR = 8'h00_25;
    // data cycles: fixed part and per step
    localparam logic [3:0] DAT_CALL_NEAR = 4'h0_2;
    localparam logic [3:0] DAT_CALL_IND_MEM = 4'h0_3;
    localparam logic [3:0] DAT_CALL_FAR = 4'h0_9;
    localparam logic [3:0] DAT_CALL_FAR_IND = 4'h0_A;
    localparam logic [3:0] DAT_JUMP_IND_REG = 4'h0_2;
    localparam logic [3:0] DAT_JUMP_IND_MEM = 4'h0_4;
    localparam logic [3:0] DAT_JUMP_FAR = 4'h0_5;
    localparam logic [3:0] DAT_TEST_MEM = 4'h0_1;
    localparam logic [3:0] DAT_BTX_MEM = 4'h0_2;
    localparam logic [1:0] DAT_STEP_ONE = 2'h0_1;
    localparam logic [1:0] DAT_STEP_TWO = 2'h0_2;
endpackage : xfer_decode_pkg
`default_nettype wire

// ### hw/op_timing_table.sv
// op timing table: base clocks, clocks per step, data cycles per class
// assumes: combinational, fed by the registered decode result
`default_nettype none
module op_timing_table
    import xfer_decode_pkg::*;
(
    // decoded operation
    input wire op_class_t op_i,
    input wire logic mem_i,
    input wire logic alt_i,
    // figures
    output logic [7:0] base_o,
    output logic [7:0] step_o,
    output logic [3:0] data_fix_o,
    output logic [1:0] data_step_o,
    output logic refill_o
);
    always_comb begin
        base_o = '0;
        step_o = '0;
        data_fix_o = '0;
        data_step_o = '0;
        refill_o = 1'b0;
        unique case (op_i)
            OP_REPEAT_COMPARE_UNTIL_MATCH: begin
                base_o = CLK_CMPS_BASE;
                step_o = CLK_CMPS_STEP;
                data_step_o = DAT_STEP_TWO;
            end
            OP_REPEAT_PORT_INPUT_STRING: begin
                base_o = alt_i ? CLK_INS_BASE_ALT : CLK_INS_BASE;
                step_o = CLK_INS_STEP;
                data_step_o = DAT_STEP_ONE;
            end
            OP_REPEAT_LOAD_STRING: begin
                base_o = CLK_LODS_BASE;
                step_o = CLK_LODS_STEP;
                data_step_o = DAT_STEP_ONE;
            end
            OP_REPEAT_MOVE_STRING: begin
                base_o = CLK_MOVS_BASE;
                step_o = CLK_MOVS_STEP;
                data_step_o = DAT_STEP_TWO;
            end
            OP_REPEAT_PORT_OUTPUT_STRING: begin
                base_o = alt_i ? CLK_OUTS_BASE_ALT : CLK_OUTS_BASE;
                step_o = CLK_OUTS_STEP;
                data_step_o = DAT_STEP_ONE;
            end
            OP_REPEAT_SCAN_WHILE_EQUAL,
            OP_REPEAT_SCAN_UNTIL_EQUAL: begin
                base_o = CLK_SCAS_BASE;
                step_o = CLK_SCAS_STEP;
                data_step_o = DAT_STEP_ONE;
            end
            OP_REPEAT_STORE_STRING: begin
                base_o = CLK_STOS_BASE;
                step_o = CLK_STOS_STEP;
                data_step_o = DAT_STEP_ONE;
            end
            OP_BIT_SCAN_FORWARD,
            OP_BIT_SCAN_REVERSE: begin
                base_o = CLK_BSCAN_BASE;
                step_o = CLK_BSCAN_STEP;
                data_step_o = DAT_STEP_TWO;
            end
            OP_BIT_TEST_PLAIN: begin
                base_o = !mem_i ? CLK_TEST_REG :
                    (alt_i ? CLK_TEST_IMM_MEM : CLK_TEST_REG_MEM);
                data_fix_o = mem_i ? DAT_TEST_MEM : 4'h0_0;
            end
            OP_BIT_TEST_COMPLEMENT,
            OP_BIT_TEST_CLEAR,
            OP_BIT_TEST_SET_OP: begin
                base_o = !mem_i ? CLK_BTX_REG :
                    (alt_i ? CLK_BTX_IMM_MEM : CLK_BTX_REG_MEM);
                data_fix_o = mem_i ? DAT_BTX_MEM : 4'h0_0;
            end
            OP_CALL_NEAR_DIRECT: begin
                base_o = CLK_CALL_NEAR;
                data_fix_o = DAT_CALL_NEAR;
                refill_o = 1'b1;
            end
            OP_CALL_NEAR_INDIRECT: begin
                base_o = mem_i ? CLK_CALL_IND_MEM : CLK_CALL_NEAR;
                data_fix_o = mem_i ? DAT_CALL_IND_MEM : DAT_CALL_NEAR;
                refill_o = 1'b1;
            end
            OP_CALL_FAR_DIRECT: begin
                base_o = CLK_CALL_FAR;
                data_fix_o = DAT_CALL_FAR;
                refill_o = 1'b1;
            end
            OP_CALL_FAR_INDIRECT: begin
                base_o = CLK_CALL_FAR_IND;
                data_fix_o = DAT_CALL_FAR_IND;
                refill_o = 1'b1;
            end
            OP_JUMP_SHORT,
            OP_JUMP_NEAR_DIRECT: begin
                base_o = CLK_JUMP_DIRECT;
                refill_o = 1'b1;
            end
            OP_JUMP_NEAR_INDIRECT: begin
                base_o = mem_i ? CLK_JUMP_IND_MEM : CLK_JUMP_IND_REG;
                data_fix_o = mem_i ? DAT_JUMP_IND_MEM : DAT_JUMP_IND_REG;
                refill_o = 1'b1;
            end
            OP_JUMP_FAR_DIRECT: begin
                base_o = CLK_JUMP_FAR;
                data_fix_o = DAT_JUMP_FAR;
                refill_o = 1'b1;
            end
            default: begin
                base_o = '0;
            end
        endcase
    end
endmodule : op_timing_table
`default_nettype wire

// ### hw/xfer_decode_timing.sv
// decode and timing of repeated string, bit and transfer operations
// assumes: opcode bytes arrive from fetch on mclk_i, already aligned;
// step count and refill count come from execution logic, same clock
`default_nettype none
module xfer_decode_timing
    import xfer_decode_pkg::*;
#(
    parameter int STEP_W = 16
) (
    // clock and reset
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // opcode bytes from fetch
    input wire logic dec_valid_i,
    input wire logic [7:0] byte0_i,
    input wire logic [7:0] byte1_i,
    input wire logic [7:0] byte2_i,
    input wire logic port_slow_i,
    // execution figures
    input wire logic [STEP_W-1:0] steps_i,
    input wire logic [7:0] refill_i,
    // decode and timing results
    output logic done_o,
    output logic known_o,
    output op_class_t op_o,
    output logic mem_o,
    output logic [STEP_W+9:0] clocks_o,
    output logic [STEP_W+5:0] data_cycles_o
);
    // ------------------------------------------------------------
    // opcode decode
    // ------------------------------------------------------------
    function automatic op_class_t str_op(input logic ne,
                                         input logic [6:0] opc);
        str_op = OP_NONE;
        if (ne) begin
            if (opc == OPC_CMPS) str_op = OP_REPEAT_COMPARE_UNTIL_MATCH;
            if (opc == OPC_SCAS) str_op = OP_REPEAT_SCAN_UNTIL_EQUAL;
        end else begin
            if (opc == OPC_INS) str_op = OP_REPEAT_PORT_INPUT_STRING;
            if (opc == OPC_LODS) str_op = OP_REPEAT_LOAD_STRING;
            if (opc == OPC_MOVS) str_op = OP_REPEAT_MOVE_STRING;
            if (opc == OPC_OUTS) str_op = OP_REPEAT_PORT_OUTPUT_STRING;
            if (opc == OPC_SCAS) str_op = OP_REPEAT_SCAN_WHILE_EQUAL;
            if (opc == OPC_STOS) str_op = OP_REPEAT_STORE_STRING;
        end
    endfunction : str_op

    op_class_t dec_op;
    logic dec_mem;
    logic dec_alt;
    logic [2:0] ext1;
    logic [2:0] ext2;

    always_comb begin
        dec_op = OP_NONE;
        dec_mem = 1'b0;
        dec_alt = 1'b0;
        ext1 = byte1_i[5:3];
        ext2 = byte2_i[5:3];
        if (byte0_i == OPC_REP_NE) begin
            dec_op = str_op(1'b1, byte1_i[7:1]);
        end else if (byte0_i == OPC_REP_E) begin
            dec_op = str_op(1'b0, byte1_i[7:1]);
            dec_alt = port_slow_i;
        end else if (byte0_i == OPC_ESCAPE) begin
            dec_mem = byte2_i[7:6] != MOD_REG;
            if (byte1_i == OPC_SCAN_FWD) begin
                dec_op = OP_BIT_SCAN_FORWARD;
            end else if (byte1_i[7:1] == OPC_SCAN_REV && byte1_i[0]) begin
                dec_op = OP_BIT_SCAN_REVERSE;
            end else if (byte1_i == OPC_TEST_REG) begin
                dec_op = OP_BIT_TEST_PLAIN;
            end else if (byte1_i == OPC_TEST_CPL_REG) begin
                dec_op = OP_BIT_TEST_COMPLEMENT;
            end else if (byte1_i == OPC_TEST_CLR_REG) begin
                dec_op = OP_BIT_TEST_CLEAR;
            end else if (byte1_i == OPC_TEST_SET_REG) begin
                dec_op = OP_BIT_TEST_SET_OP;
            end else if (byte1_i == OPC_TEST_GRP) begin
                dec_alt = 1'b1;
                unique case (ext2)
                    EXT_TEST: dec_op = OP_BIT_TEST_PLAIN;
                    EXT_TEST_CPL: dec_op = OP_BIT_TEST_COMPLEMENT;
                    EXT_TEST_CLR: dec_op = OP_BIT_TEST_CLEAR;
                    EXT_TEST_SET: dec_op = OP_BIT_TEST_SET_OP;
                    default: dec_op = OP_NONE;
                endcase
            end
        end else if (byte0_i == OPC_CALL_NEAR) begin
            dec_op = OP_CALL_NEAR_DIRECT;
        end else if (byte0_i == OPC_CALL_FAR) begin
            dec_op = OP_CALL_FAR_DIRECT;
        end else if (byte0_i == OPC_JUMP_SHORT) begin
            dec_op = OP_JUMP_SHORT;
        end else if (byte0_i == OPC_JUMP_NEAR) begin
            dec_op = OP_JUMP_NEAR_DIRECT;
        end else if (byte0_i == OPC_JUMP_FAR) begin
            dec_op = OP_JUMP_FAR_DIRECT;
        end else if (byte0_i == OPC_GRP_FF) begin
            dec_mem = byte1_i[7:6] != MOD_REG;
            unique case (ext1)
                EXT_CALL_NEAR: dec_op = OP_CALL_NEAR_INDIRECT;
                EXT_CALL_FAR: dec_op = OP_CALL_FAR_INDIRECT;
                EXT_JUMP_NEAR: dec_op = OP_JUMP_NEAR_INDIRECT;
                default: dec_op = OP_NONE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // stage 1: registered decode and operands
    // ------------------------------------------------------------
    logic s1_valid_reg, s1_valid_next;
    op_class_t s1_op_reg, s1_op_next;
    logic s1_mem_reg, s1_mem_next;
    logic s1_alt_reg, s1_alt_next;
    logic [STEP_W-1:0] s1_steps_reg, s1_steps_next;
    logic [7:0] s1_refill_reg, s1_refill_next;

    always_comb begin
        s1_valid_next = dec_valid_i;
        s1_op_next = dec_valid_i ? dec_op : s1_op_reg;
        s1_mem_next = dec_valid_i ? dec_mem : s1_mem_reg;
        s1_alt_next = dec_valid_i ? dec_alt : s1_alt_reg;
        s1_steps_next = dec_valid_i ? steps_i : s1_steps_reg;
        s1_refill_next = dec_valid_i ? refill_i : s1_refill_reg;
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            s1_valid_reg <= 1'b0;
            s1_op_reg <= OP_NONE;
            s1_mem_reg <= 1'b0;
            s1_alt_reg <= 1'b0;
            s1_steps_reg <= '0;
            s1_refill_reg <= '0;
        end else begin
            s1_valid_reg <= s1_valid_next;
            s1_op_reg <= s1_op_next;
            s1_mem_reg <= s1_mem_next;
            s1_alt_reg <= s1_alt_next;
            s1_steps_reg <= s1_steps_next;
            s1_refill_reg <= s1_refill_next;
        end
    end

    // ------------------------------------------------------------
    // stage 2: clock and data cycle totals
    // ------------------------------------------------------------
    logic [7:0] t_base;
    logic [7:0] t_step;
    logic [3:0] t_dfix;
    logic [1:0] t_dstep;
    logic t_refill;

    op_timing_table u_table (
        .op_i(s1_op_reg),
        .mem_i(s1_mem_reg),
        .alt_i(s1_alt_reg),
        .base_o(t_base),
        .step_o(t_step),
        .data_fix_o(t_dfix),
        .data_step_o(t_dstep),
        .refill_o(t_refill)
    );

    logic done_reg, done_next;
    logic known_reg, known_next;
    op_class_t op_reg, op_next;
    logic mem_reg, mem_next;
    logic [STEP_W+9:0] clocks_reg, clocks_next;
    logic [STEP_W+5:0] data_reg, data_next;

    always_comb begin
        done_next = s1_valid_reg;
        known_next = known_reg;
        op_next = op_reg;
        mem_next = mem_reg;
        clocks_next = clocks_reg;
        data_next = data_reg;
        if (s1_valid_reg) begin
            known_next = s1_op_reg != OP_NONE;
            op_next = s1_op_reg;
            mem_next = s1_mem_reg;
            // base + step*n, plus m only when t_refill
            clocks_next = (STEP_W+10)'(t_base)
                + (STEP_W+10)'(t_step) * (STEP_W+10)'(s1_steps_reg)
                + (t_refill ? (STEP_W+10)'(s1_refill_reg)
                            : (STEP_W+10)'(0));
            data_next = (STEP_W+6)'(t_dfix)
                + (STEP_W+6)'(t_dstep) * (STEP_W+6)'(s1_steps_reg);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            done_reg <= 1'b0;
            known_reg <= 1'b0;
            op_reg <= OP_NONE;
            mem_reg <= 1'b0;
            clocks_reg <= '0;
            data_reg <= '0;
        end else begin
            done_reg <= done_next;
            known_reg <= known_next;
            op_reg <= op_next;
            mem_reg <= mem_next;
            clocks_reg <= clocks_next;
            data_reg <= data_next;
        end
    end

    assign done_o = done_reg;
    assign known_o = known_reg;
    assign op_o = op_reg;
    assign mem_o = mem_reg;
    assign clocks_o = clocks_reg;
    assign data_cycles_o = data_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking chk_cb @(posedge mclk_i);
    endclocking

    default disable iff (!rst_n_i);

    sequence s_take(logic [7:0] b0, logic [7:0] b1);
        dec_valid_i && byte0_i == b0 && byte1_i == b1;
    endsequence

    sequence s_take_one(logic [7:0] b0);
        dec_valid_i && byte0_i == b0;
    endsequence

    a_cmps_totals: assert property (
        s_take(OPC_REP_NE, {OPC_CMPS, 1'b1}) |-> ##2 done_o
        && clocks_o == 5 + 9 * $past(steps_i, 2)
        && data_cycles_o == 2 * $past(steps_i, 2))
        else $error("repeat compare totals wrong");
    a_movs_totals: assert property (
        s_take(OPC_REP_E, {OPC_MOVS, 1'b0}) |-> ##2
        clocks_o == 7 + 4 * $past(steps_i, 2))
        else $error("repeat move clocks wrong");
    a_scan_class: assert property (
        s_take(OPC_REP_E, {OPC_SCAS, 1'b0}) |-> ##2
        op_o == OP_REPEAT_SCAN_WHILE_EQUAL)
        else $error("scan while equal not decoded");
    a_scanne_class: assert property (
        s_take(OPC_REP_NE, {OPC_SCAS, 1'b1}) |-> ##2
        op_o == OP_REPEAT_SCAN_UNTIL_EQUAL
        && clocks_o == 5 + 8 * $past(steps_i, 2))
        else $error("scan until equal wrong");
    a_fwd_scan_clocks: assert property (
        s_take(OPC_ESCAPE, OPC_SCAN_FWD) |-> ##2
        clocks_o == 10 + 3 * $past(steps_i, 2))
        else $error("forward bit scan clocks wrong");
    a_far_call: assert property (
        s_take_one(OPC_CALL_FAR) |-> ##2
        clocks_o == 42 + $past(refill_i, 2) && data_cycles_o == 9)
        else $error("far call totals wrong");
    a_short_jump: assert property (
        s_take_one(OPC_JUMP_SHORT) |-> ##2
        clocks_o == 7 + $past(refill_i, 2) && data_cycles_o == 0)
        else $error("short jump totals wrong");
    a_far_jump: assert property (
        s_take_one(OPC_JUMP_FAR) |-> ##2
        clocks_o == 37 + $past(refill_i, 2) && data_cycles_o == 5)
        else $error("far jump totals wrong");
    a_ind_jump_mem: assert property (
        dec_valid_i && byte0_i == OPC_GRP_FF
        && byte1_i[5:3] == EXT_JUMP_NEAR
        && byte1_i[7:6] != MOD_REG |-> ##2
        clocks_o == 14 + $past(refill_i, 2) && data_cycles_o == 4)
        else $error("indirect jump memory totals wrong");
    a_done_pulse: assert property (
        done_o |-> $past(dec_valid_i, 2))
        else $error("done without a request");
endmodule : xfer_decode_timing
`default_nettype wire

// ### verification/string_bit_branch_decode_timing_test.sv
// bench: random opcode stream against a table model of the decoder
// assumes: xfer_decode_timing with default step width, result 2 edges late
`default_nettype none
module string_bit_branch_decode_timing_test;
    timeunit 1ns;
    timeprecision 1ps;
    import xfer_decode_pkg::*;
    typedef struct {int o; int c; int d; int m; int due;} exp_t;
    logic mclk_i, rst_n_i, dec_valid_i, port_slow_i;
    logic [7:0] byte0_i, byte1_i, byte2_i, refill_i;
    logic [15:0] steps_i;
    logic done_o, known_o, mem_o;
    op_class_t op_o;
    logic [25:0] clocks_o;
    logic [21:0] data_cycles_o;
    int num_errors = 0;
    int cmp_count = 0;
    int cyc = 0;
    exp_t pend[$];
    exp_t e;
    logic [7:0] t0[9] = '{8'hF2, 8'hF3, 8'h0F, 8'hE8, 8'h9A, 8'hFF, 8'hEB,
        8'hE9, 8'hEA};
    logic [7:0] t1[14] = '{8'hA6, 8'h6C, 8'hAC, 8'hA4, 8'h6E, 8'hAE, 8'hAA,
        8'hBC, 8'hBD, 8'hBA, 8'hA3, 8'hBB, 8'hB3, 8'hAB};
    xfer_decode_timing #(.STEP_W(16)) dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
        .dec_valid_i(dec_valid_i), .byte0_i(byte0_i), .byte1_i(byte1_i),
        .byte2_i(byte2_i), .port_slow_i(port_slow_i), .steps_i(steps_i),
        .refill_i(refill_i), .done_o(done_o), .known_o(known_o), .op_o(op_o),
        .mem_o(mem_o), .clocks_o(clocks_o), .data_cycles_o(data_cycles_o));
    // ----------------------------------------
    // model
    // ----------------------------------------
    function automatic exp_t f(int o, int c, int d, int m);
        f = '{o, c, d, m, 0};
    endfunction : f
    function automatic exp_t model(logic [7:0] b0, b1, b2, logic s,
        int n, int k);
        logic r;
        logic q;
        r = b2[7:6] != 2'b11;
        q = b1[7:6] != 2'b11;
        model = f(0, 0, 0, 2);
        if (b0 == 8'hF2 || b0 == 8'hF3) begin
            case ({b0[0], b1[7:1]})
                8'h53: model = f(1, 5 + 9 * n, 2 * n, 2);
                8'hB6: model = f(2, (s ? 27 : 7) + 6 * n, n, 2);
                8'hD6: model = f(3, 5 + 6 * n, n, 2);
                8'hD2: model = f(4, 7 + 4 * n, 2 * n, 2);
                8'hB7: model = f(5, (s ? 26 : 6) + 5 * n, n, 2);
                8'hD7: model = f(6, 5 + 8 * n, n, 2);
                8'h57: model = f(7, 5 + 8 * n, n, 2);
                8'hD5: model = f(8, 5 + 5 * n, n, 2);
                default: ;
            endcase
        end else if (b0 == 8'h0F) begin
            case (b1)
                8'hBC: model = f(9, 10 + 3 * n, 2 * n, r);
                8'hBD: model = f(10, 10 + 3 * n, 2 * n, r);
                8'hA3: model = f(11, r ? 12 : 3, r, r);
                8'hBB: model = f(12, r ? 13 : 6, 2 * r, r);
                8'hB3: model = f(13, r ? 13 : 6, 2 * r, r);
                8'hAB: model = f(14, r ? 13 : 6, 2 * r, r);
                8'hBA: begin
                    if (b2[5:3] == 3'd4) model = f(11, r ? 6 : 3, r, r);
                    else if (b2[5]) model = f(19 - b2[5:3], r ? 8 : 6, 2 * r,
                        r);
                end
                default: ;
            endcase
        end else begin
            case (b0)
                8'hE8: model = f(15, 9 + k, 2, 0);
                8'h9A: model = f(17, 42 + k, 9, 0);
                8'hEB: model = f(19, 7 + k, 0, 2);
                8'hE9: model = f(20, 7 + k, 0, 0);
                8'hEA: model = f(22, 37 + k, 5, 0);
                8'hFF: begin
                    case (b1[5:3])
                        3'd2: model = f(16, (q ? 12 : 9) + k, 2 + q, q);
                        3'd3: model = f(18, 46 + k, 10, q);
                        3'd4: model = f(21, (q ? 14 : 9) + k, 2 + 2 * q, q);
                        default: ;
                    endcase
                end
                default: ;
            endcase
        end
    endfunction : model
    // ----------------------------------------
    // checking and reporting
    // ----------------------------------------
    task automatic err(string s);
        num_errors++;
        $display("[ERR] %0t %s", $time, s);
    endtask : err
    task automatic check(exp_t x);
        cmp_count++;
        if (op_o !== op_class_t'(x.o) || known_o !== (x.o != 0)
            || clocks_o !== 26'(x.c) || data_cycles_o !== 22'(x.d)
            || (x.m != 2 && mem_o !== x.m[0])) begin
            err("decode result mismatch");
        end
    endtask : check
    task automatic monitor;
        if (done_o === 1'b1) begin
            if (pend.size() == 0 || pend[0].due != cyc) err("stray done");
            else check(pend.pop_front());
        end else if (pend.size() != 0 && pend[0].due <= cyc) begin
            err("done missing");
            void'(pend.pop_front());
        end
    endtask : monitor
    task automatic close_out;
        $display("compares %0d errors %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : close_out
    // ----------------------------------------
    // clock, timeout, stimulus
    // ----------------------------------------
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 3000) begin
            err("timeout");
            close_out();
        end
    end
    initial begin
        {rst_n_i, dec_valid_i, port_slow_i, byte0_i, byte1_i} = '0;
        {byte2_i, refill_i, steps_i} = '0;
        void'($urandom(64));
        repeat (2) @(negedge mclk_i);
        check(f(0, 0, 0, 0));
        rst_n_i = 1'b1;
        repeat (800) begin
            @(negedge mclk_i);
            monitor();
            dec_valid_i = ($urandom % 4) != 0;
            byte0_i = ($urandom % 10 == 9) ? 8'($urandom) : t0[$urandom % 9];
            byte1_i = ($urandom % 3 == 0) ? 8'($urandom)
                : (t1[$urandom % 14] | 8'($urandom % 2));
            byte2_i = 8'($urandom);
            port_slow_i = 1'($urandom);
            steps_i = 16'($urandom % 20);
            refill_i = 8'($urandom % 16);
            if (dec_valid_i) begin
                e = model(byte0_i, byte1_i, byte2_i, port_slow_i,
                    int'(steps_i), int'(refill_i));
                e.due = cyc + 2;
                pend.push_back(e);
            end
        end
        repeat (5) begin
            @(negedge mclk_i);
            monitor();
            dec_valid_i = 1'b0;
        end
        close_out();
    end
endmodule : string_bit_branch_decode_timing_test
`default_nettype wire
